/* pwm_steer_map.svh */
// Register offsets, field positions and reset values of the steering block
`ifndef PWM_STEER_MAP_SVH
`define PWM_STEER_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_SHDN 8'h04
`define OFS_TSEL_LO 8'h08
`define OFS_TSEL_HI 8'h0c
`define OFS_STEER 8'h10
`define OFS_EPWM 8'h14
`define OFS_STATUS 8'h18
`define OFS_DIR 8'h1c
`define OFS_LATCH 8'h20
`define OFS_ALT 8'h24
`define ADDR_MSB 7
`define RST_BYTE 8'h00
`define RST_DIR 4'hf
`define MASK_TSEL_HI 8'h03
`define MASK_STEER 8'h1f
`define MASK_CFG 8'h3f
`define MODE_PWM 2'h3
`define CFG_SINGLE 2'h0
`define TSEL_NONE 2'h3
`define BIT_SYNC 4
`define BIT_ASE 7
`define BIT_RSEN 7
`define BIT_TPF 0
`define BIT_FIRST 1
`define FIRST_CNT 2'h2
`endif

/* pwm_steer_pkg.sv */
// Types shared by the steering block
package pwm_steer_pkg;
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] period;
    } timer_bus_s;
    typedef struct packed {
        logic [1:0] out_cfg;
        logic [1:0] duty_lo;
        logic [3:0] mode;
    } ctrl_reg_s;
    typedef struct packed {
        logic ase;
        logic [2:0] src;
        logic [1:0] pss_ac;
        logic [1:0] pss_bd;
    } shdn_reg_s;
    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } pin_grp_s;
endpackage : pwm_steer_pkg

/* pwm_steer_sync.sv */
// Two-flop synchronisers for the asynchronous shutdown inputs
`timescale 1ns/10ps
module pwm_steer_sync #(
    parameter int W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_sync
            logic meta_r;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r <= 1'b0;
                    sync_out[g] <= 1'b0;
                end else begin
                    meta_r <= async_in[g];
                    sync_out[g] <= meta_r;
                end
            end
        end
    endgenerate
endmodule : pwm_steer_sync

/* pwm_output_steering.sv */
// Single-output PWM steering, polarity and shutdown with an APB slave
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps
`include "pwm_steer_map.svh"
module pwm_output_steering #(
    parameter bit ENHANCED = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pwm_steer_pkg::timer_bus_s [2:0] timers,
    input wire logic pwm_raw,
    input wire logic fault_input_pin_n,
    input wire logic comp1_high,
    input wire logic comp2_high,
    output pwm_steer_pkg::pin_grp_s pin_pri,
    output pwm_steer_pkg::pin_grp_s pin_alt,
    output logic timer_period_flag,
    output logic shutdown_event_flag
);
    pwm_steer_pkg::ctrl_reg_s ctrl_r;
    pwm_steer_pkg::shdn_reg_s shdn_r;
    logic [7:0] tsel_lo_r;
    logic [7:0] tsel_hi_r;
    logic [4:0] steer_r;
    logic [3:0] steer_act_r;
    logic [7:0] epwm_r;
    logic [3:0] dir_r;
    logic [3:0] latch_r;
    logic [3:0] alt_r;
    logic tpf_r;
    logic [1:0] first_cnt_r;
    logic shut_hold_r;
    logic [3:0] pin_o_r;
    logic [3:0] pin_oe_r;
    logic [2:0] src_sync;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [7:0] rd_nxt;
    logic boundary;
    logic steer_on;
    logic shdn_cond;
    logic shut_eff;
    logic [1:0] tsel;
    logic [7:0] wbyte;

    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    // Shutdown inputs arrive from pins and comparators
    pwm_steer_sync #(.W(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({!fault_input_pin_n, comp2_high, comp1_high}),
        .sync_out(src_sync)
    );

    assign tsel = tsel_lo_r[1:0];
    always_comb begin
        boundary = 1'b0;
        if (tsel != `TSEL_NONE) begin
            boundary = timers[tsel].count == timers[tsel].period;
        end
    end

    assign steer_on = (ctrl_r.mode[3:2] == `MODE_PWM) &&
                      (!ENHANCED || ctrl_r.out_cfg == `CFG_SINGLE);

    assign shdn_cond = (shdn_r.src[2] && src_sync[2]) ||
                       (shdn_r.src[1] && src_sync[1]) ||
                       (shdn_r.src[0] && src_sync[0]);
    assign shut_eff = shdn_r.ase || shut_hold_r;
    assign shutdown_event_flag = shdn_r.ase;
    assign timer_period_flag = tpf_r;

    always_comb begin
        hit = 1'b1;
        rd_nxt = `RST_BYTE;
        unique case (paddr[`ADDR_MSB:0])
            `OFS_CTRL: rd_nxt = ENHANCED ? ctrl_r : (ctrl_r & `MASK_CFG);
            `OFS_SHDN: rd_nxt = shdn_r;
            `OFS_TSEL_LO: rd_nxt = tsel_lo_r;
            `OFS_TSEL_HI: rd_nxt = tsel_hi_r & `MASK_TSEL_HI;
            `OFS_STEER: rd_nxt = {3'h0, steer_r};
            `OFS_EPWM: rd_nxt = epwm_r;
            `OFS_STATUS: rd_nxt = {steer_act_r, 1'b0, shdn_cond,
                                   first_cnt_r == `FIRST_CNT, tpf_r};
            `OFS_DIR: rd_nxt = {4'h0, dir_r};
            `OFS_LATCH: rd_nxt = {4'h0, latch_r};
            `OFS_ALT: rd_nxt = {4'h0, alt_r};
            default: hit = 1'b0;
        endcase
        if (|paddr[31:`ADDR_MSB+1]) begin
            hit = 1'b0;
            rd_nxt = `RST_BYTE;
        end
    end

    assign pslverr = psel && penable && !hit;

    // Read data registered in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= {24'h0, rd_nxt};
        end
    end

    // Plain configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `RST_BYTE;
            tsel_lo_r <= `RST_BYTE;
            tsel_hi_r <= `RST_BYTE;
            epwm_r <= `RST_BYTE;
            latch_r <= 4'h0;
            alt_r <= 4'h0;
            dir_r <= `RST_DIR;
        end else if (wr_en && hit) begin
            unique case (paddr[`ADDR_MSB:0])
                `OFS_CTRL: ctrl_r <= wbyte;
                `OFS_TSEL_LO: tsel_lo_r <= wbyte;
                `OFS_TSEL_HI: tsel_hi_r <= wbyte & `MASK_TSEL_HI;
                `OFS_EPWM: epwm_r <= wbyte;
                `OFS_LATCH: latch_r <= wbyte[3:0];
                `OFS_ALT: alt_r <= wbyte[3:0];
                `OFS_DIR: dir_r <= wbyte[3:0];
                default: ;
            endcase
        end
    end

    // Steering register and active enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steer_r <= 5'h0;
            steer_act_r <= 4'h0;
        end else begin
            if (wr_en && paddr[`ADDR_MSB:0] == `OFS_STEER &&
                paddr[31:`ADDR_MSB+1] == '0) begin
                steer_r <= wbyte[4:0];
                if (!wbyte[`BIT_SYNC]) begin
                    steer_act_r <= wbyte[3:0];
                end
            end else if (steer_r[`BIT_SYNC] && boundary) begin
                steer_act_r <= steer_r[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shdn_r <= `RST_BYTE;
        end else begin
            if (wr_en && paddr == {24'h0, `OFS_SHDN}) begin
                shdn_r[6:0] <= wbyte[6:0];
                // Writes to the flag are locked out while the cause persists
                if (!shdn_cond) begin
                    shdn_r.ase <= wbyte[`BIT_ASE];
                end
            end
            if (shdn_cond) begin
                shdn_r.ase <= 1'b1;
            end else if (epwm_r[`BIT_RSEN] &&
                         !(wr_en && paddr == {24'h0, `OFS_SHDN})) begin
                shdn_r.ase <= 1'b0;
            end
        end
    end

    // Output resumes only on a whole period after the flag clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shut_hold_r <= 1'b0;
        end else if (shdn_r.ase) begin
            shut_hold_r <= 1'b1;
        end else if (boundary) begin
            shut_hold_r <= 1'b0;
        end
    end

    // period flag and first full cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tpf_r <= 1'b0;
            first_cnt_r <= 2'h0;
        end else begin
            if (wr_en && paddr == {24'h0, `OFS_STATUS} &&
                wbyte[`BIT_TPF]) begin
                tpf_r <= 1'b0;
            end
            if (boundary) begin
                tpf_r <= 1'b1;
            end
            if (!steer_on) begin
                first_cnt_r <= 2'h0;
            end else if (boundary && first_cnt_r != `FIRST_CNT) begin
                first_cnt_r <= first_cnt_r + 2'h1;
            end
        end
    end

    // Per-pin output selection
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_pin
            logic pol;
            logic [1:0] pss;
            logic steered;
            logic val;
            logic drive;
            assign pol = (i % 2 == 0) ? ctrl_r.mode[1] : ctrl_r.mode[0];
            assign pss = (i % 2 == 0) ? shdn_r.pss_ac : shdn_r.pss_bd;
            assign steered = steer_on && steer_act_r[i];
            always_comb begin
                val = latch_r[i];
                drive = 1'b1;
                if (steered && shut_eff) begin
                    val = pss[0];
                    drive = !pss[1];
                end else if (steered) begin
                    val = pwm_raw ^ pol;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_o_r[i] <= 1'b0;
                    pin_oe_r[i] <= 1'b0;
                end else begin
                    pin_o_r[i] <= val;
                    pin_oe_r[i] <= drive && !dir_r[i];
                end
            end
            assign pin_pri.o[i] = pin_o_r[i];
            assign pin_alt.o[i] = pin_o_r[i];
            assign pin_pri.oe[i] = pin_oe_r[i] && !alt_r[i];
            assign pin_alt.oe[i] = pin_oe_r[i] && alt_r[i];
        end
    endgenerate

    AST_IMMEDIATE_STEER: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == {24'h0, `OFS_STEER} && !pwdata[`BIT_SYNC]
        |=> steer_act_r == $past(pwdata[3:0]))
        else $error("steering not applied at once");
    AST_SYNC_WAIT: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(wr_en && paddr == {24'h0, `OFS_STEER}) && !boundary
        |=> $stable(steer_act_r))
        else $error("steering changed off a boundary");
    AST_SYNC_LOAD: assert property (
        @(posedge pclk) disable iff (!presetn)
        steer_r[`BIT_SYNC] && boundary && !wr_en
        |=> steer_act_r == $past(steer_r[3:0]))
        else $error("pending steering not loaded");
    AST_SHDN_FLAG: assert property (
        @(posedge pclk) disable iff (!presetn)
        shdn_cond |=> shdn_r.ase)
        else $error("shutdown flag not set");
    AST_SHDN_PIN: assert property (
        @(posedge pclk) disable iff (!presetn)
        steer_on && steer_act_r[0] && shdn_r.ase && !shdn_r.pss_ac[1]
        && $stable(shdn_r) && $stable(steer_act_r) && $stable(ctrl_r)
        |=> pin_o_r[0] == $past(shdn_r.pss_ac[0]))
        else $error("pin A not in shutdown state");
    AST_UNSTEERED_LATCH: assert property (
        @(posedge pclk) disable iff (!presetn)
        !steer_act_r[1] && $stable(latch_r)
        |=> pin_o_r[1] == $past(latch_r[1]))
        else $error("unsteered pin B not from latch");
    AST_POLARITY: assert property (
        @(posedge pclk) disable iff (!presetn)
        steer_on && steer_act_r[2] && !shut_eff
        |=> pin_o_r[2] == ($past(pwm_raw) ^ $past(ctrl_r.mode[1])))
        else $error("pin C polarity wrong");
    AST_HIZ_DIR: assert property (
        @(posedge pclk) disable iff (!presetn)
        dir_r[3] |=> !pin_pri.oe[3] && !pin_alt.oe[3])
        else $error("pin D driven while input");
    AST_RESERVED_ZERO: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_en && paddr == {24'h0, `OFS_STEER} ##1 1'b1
        |-> prdata[31:5] == 27'h0)
        else $error("unused steering bits not zero");
    AST_PERIOD_FLAG: assert property (
        @(posedge pclk) disable iff (!presetn)
        boundary |=> tpf_r)
        else $error("period flag missing");
    AST_UNSTEERED_SHDN: assert property (
        @(posedge pclk) disable iff (!presetn)
        !steer_act_r[1] && shut_eff
        |=> pin_o_r[1] == $past(latch_r[1])
            && pin_oe_r[1] == !$past(dir_r[1]))
        else $error("unsteered pin B touched by shutdown");
    AST_STEER_OFF: assert property (
        @(posedge pclk) disable iff (!presetn)
        !steer_on |=> pin_o_r[2] == $past(latch_r[2]))
        else $error("pin C steered outside single-output mode");
    AST_PAIR_BD: assert property (
        @(posedge pclk) disable iff (!presetn)
        steer_on && steer_act_r[3] && !shut_eff
        |=> pin_o_r[3] == ($past(pwm_raw) ^ $past(ctrl_r.mode[0])))
        else $error("pin D polarity wrong");
    AST_TRI_STATE: assert property (
        @(posedge pclk) disable iff (!presetn)
        steer_on && steer_act_r[2] && shut_eff && shdn_r.pss_ac[1]
        |=> !pin_oe_r[2])
        else $error("pin C not released in shutdown");
    AST_AUTO_RESTART: assert property (
        @(posedge pclk) disable iff (!presetn)
        epwm_r[`BIT_RSEN] && !shdn_cond && !wr_en
        |=> !shdn_r.ase)
        else $error("auto-restart did not clear the flag");
    AST_NO_TIMER: assert property (
        @(posedge pclk) disable iff (!presetn)
        tsel == `TSEL_NONE && !tpf_r
        |=> !tpf_r)
        else $error("period flag set with no timer");
endmodule : pwm_output_steering

/* pwm_switch_model.sv */
// Power switch driver model seen at the four primary pads
`timescale 1ns/10ps
module pwm_switch_model (
    input wire pwm_steer_pkg::pin_grp_s pins,
    output logic [3:0] pad
);
    // pull-down keeps switches off
    // Undriven pads read low, never the last driven value
    assign pad = pins.oe & pins.o;
endmodule : pwm_switch_model

/* pwm_output_steering_tb_top.sv */
// Self-checking bench for the output steering block
`timescale 1ns/10ps
`include "pwm_steer_map.svh"
module pwm_output_steering_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic pwm_raw = 1'b0;
    logic comp1_high = 1'b0;
    logic comp2_high = 1'b0;
    logic fault_input_pin_n = 1'b1;
    pwm_steer_pkg::timer_bus_s [2:0] timers = {3{16'h0007}};
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pwm_steer_pkg::pin_grp_s pin_pri;
    pwm_steer_pkg::pin_grp_s pin_alt;
    logic timer_period_flag;
    logic shutdown_event_flag;
    logic [3:0] pad;
    logic [31:0] rd;
    logic er;
    logic [3:0] md;
    logic [3:0] st;
    logic [3:0] lat;
    logic [1:0] cf;
    int err_total = 0;
    int check_count = 0;
    int seed = 73972;
    always #10 pclk = ~pclk;
    // Timer 0 wraps after matching its period
    always @(posedge pclk) begin
        if (timers[0].count == timers[0].period) begin
            timers[0].count <= 8'h00;
        end else begin
            timers[0].count <= timers[0].count + 8'h01;
        end
    end
    pwm_output_steering pwm_output_steering_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timers(timers),
        .pwm_raw(pwm_raw), .fault_input_pin_n(fault_input_pin_n),
        .comp1_high(comp1_high), .comp2_high(comp2_high), .pin_pri(pin_pri),
        .pin_alt(pin_alt), .timer_period_flag(timer_period_flag),
        .shutdown_event_flag(shutdown_event_flag)
    );
    pwm_switch_model pwm_switch_model_i (.pins(pin_pri), .pad(pad));
    task automatic results;
        $display("Mismatches %0d of %0d checks", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] ex,
        input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
            err_total++;
        end
    endtask : chk
    // Upper data bits set on purpose: they must be ignored
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= {24'hffffff, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            err_total++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_cnt(input logic [7:0] v);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (timers[0].count !== v && n < 40);
        if (n >= 40) begin
            err_total++;
            results();
        end
    endtask : wait_cnt
    function automatic logic [7:0] exp_pins(input logic raw,
        input logic sd, input logic [3:0] pss);
        logic [3:0] o;
        logic [3:0] oe;
        logic [1:0] ps;
        o = lat;
        oe = 4'hf;
        for (int i = 0; i < 4; i++) begin
            ps = i[0] ? pss[1:0] : pss[3:2];
            if (md[3:2] == 2'h3 && cf == 2'h0 && st[i]) begin
                o[i] = raw ^ (i[0] ? md[0] : md[1]);
                if (sd) begin
                    o[i] = ps[0];
                    oe[i] = ~ps[1];
                end
            end
        end
        return {oe, oe & o};
    endfunction : exp_pins
    task automatic pins(input logic sd, input logic [3:0] pss);
        chk("pins", 32'(exp_pins(pwm_raw, sd, pss)), 32'({pin_pri.oe, pad}));
    endtask : pins
    initial begin
        logic [7:0] r;
        repeat (4) @(posedge pclk);
        chk("reset pins", 32'h0, 32'({pin_pri.oe, pin_alt.oe, pad}));
        presetn <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            apb(1'b0, 8'(a * 4), 8'h00);
            if (a != 6) begin
                chk("reset value", (a == 7) ? 32'hf : 32'h0, rd);
            end
            chk("slave error", 32'h0, 32'(er));
        end
        apb(1'b0, 8'h28, 8'h00);
        chk("unmapped err", 32'h1, 32'(er));
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, `OFS_STEER, 8'hef);
        apb(1'b0, `OFS_STEER, 8'h00);
        chk("steer bits", 32'h0f, rd);
        apb(1'b1, `OFS_TSEL_HI, 8'hff);
        apb(1'b0, `OFS_TSEL_HI, 8'h00);
        chk("timer sel bits", 32'h03, rd);
        apb(1'b1, `OFS_CTRL, 8'h0c);
        wait_cnt(8'h01);
        apb(1'b1, `OFS_STATUS, 8'h01);
        @(posedge pclk);
        chk("flag cleared", 32'h0, 32'(timer_period_flag));
        wait_cnt(8'h07);
        chk("flag early", 32'h0, 32'(timer_period_flag));
        @(posedge pclk);
        chk("flag set", 32'h1, 32'(timer_period_flag));
        // No timer selected: no boundary, flag stays clear
        apb(1'b1, `OFS_TSEL_LO, 8'h03);
        apb(1'b1, `OFS_STATUS, 8'h01);
        wait_cnt(8'h07);
        repeat (2) @(posedge pclk);
        chk("no timer", 32'h0, 32'(timer_period_flag));
        apb(1'b1, `OFS_TSEL_LO, 8'h00);
        // Polarity changed only while drivers are off
        for (int k = 0; k < 16; k++) begin
            r = 8'($random(seed));
            md = r[2] ? {2'b11, r[1:0]} : 4'h0;
            st = r[7:4];
            cf = r[3] ? 2'($random(seed)) : 2'h0;
            lat = 4'($random(seed));
            apb(1'b1, `OFS_DIR, 8'h0f);
            apb(1'b1, `OFS_CTRL, {cf, 2'h0, md});
            apb(1'b1, `OFS_LATCH, {4'h0, lat});
            apb(1'b1, `OFS_STEER, {4'h0, st});
            repeat (9) @(posedge pclk);
            apb(1'b1, `OFS_DIR, 8'h00);
            for (int b = 0; b < 2; b++) begin
                pwm_raw <= b[0];
                repeat (2) @(posedge pclk);
                pins(1'b0, 4'h0);
            end
        end
        md = 4'hc;
        cf = 2'h0;
        st = 4'h1;
        lat = 4'h0;
        apb(1'b1, `OFS_DIR, 8'h0f);
        apb(1'b1, `OFS_CTRL, 8'h0c);
        apb(1'b1, `OFS_LATCH, 8'h00);
        apb(1'b1, `OFS_STEER, 8'h01);
        repeat (9) @(posedge pclk);
        apb(1'b1, `OFS_DIR, 8'h00);
        pwm_raw <= 1'b1;
        wait_cnt(8'h01);
        apb(1'b1, `OFS_STEER, 8'h12);
        apb(1'b0, `OFS_STATUS, 8'h00);
        chk("steer held", 32'h1, 32'(rd[7:4]));
        pins(1'b0, 4'h0);
        wait_cnt(8'h07);
        repeat (2) @(posedge pclk);
        st = 4'h2;
        pins(1'b0, 4'h0);
        apb(1'b1, `OFS_STEER, 8'h05);
        apb(1'b1, `OFS_EPWM, 8'h80);
        st = 4'h5;
        pwm_raw <= 1'b0;
        // Each shutdown state of the steered pair, unsteered other pair drives its latch value 0
        for (int p = 0; p < 3; p++) begin
            // Source per pass: comparator 1, comparator 2, fault pin
            apb(1'b1, `OFS_SHDN, {1'b0, 3'(1 << p), p[1:0], 2'b01});
            comp1_high <= (p == 0);
            comp2_high <= (p == 1);
            fault_input_pin_n <= (p != 2);
            repeat (6) @(posedge pclk);
            chk("sd flag", 32'h1, 32'(shutdown_event_flag));
            pins(1'b1, {p[1:0], 2'b01});
            apb(1'b1, `OFS_SHDN, {1'b0, 3'(1 << p), p[1:0], 2'b01});
            @(posedge pclk);
            chk("sd held", 32'h1, 32'(shutdown_event_flag));
            comp1_high <= 1'b0;
            comp2_high <= 1'b0;
            fault_input_pin_n <= 1'b1;
            repeat (6) @(posedge pclk);
            chk("sd restart", 32'h0, 32'(shutdown_event_flag));
            wait_cnt(8'h07);
            repeat (2) @(posedge pclk);
            pins(1'b0, 4'h0);
        end
        // Without auto-restart the flag waits for software
        apb(1'b1, `OFS_EPWM, 8'h00);
        apb(1'b1, `OFS_SHDN, 8'h15);
        comp1_high <= 1'b1;
        repeat (6) @(posedge pclk);
        comp1_high <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("sd sticky", 32'h1, 32'(shutdown_event_flag));
        apb(1'b1, `OFS_SHDN, 8'h15);
        @(posedge pclk);
        chk("sd cleared", 32'h0, 32'(shutdown_event_flag));
        wait_cnt(8'h07);
        repeat (2) @(posedge pclk);
        pwm_raw <= 1'b1;
        apb(1'b1, `OFS_ALT, 8'h01);
        repeat (2) @(posedge pclk);
        chk("alt enable", 32'h1e, 32'({pin_alt.oe, pin_pri.oe}));
        chk("alt data", 32'h1, 32'(pin_alt.o[0]));
        results();
    end
endmodule : pwm_output_steering_tb_top
